// file: smart_attribute_record_builder.sv
// Builds the six 12-byte health attribute records of the health data sector.
// Assumes all inputs come from card-controller logic on core_clk.
`timescale 1ns/10ps
`include "smart_rec_params.svh"
module smart_attribute_record_builder (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        flashReadActive,
    input  wire logic        flashReadDone,
    input  wire logic        eccCorrected,
    input  wire logic        eccUncorrectable,
    input  wire logic        udmaCrcError,
    input  wire logic        blockErased,
    input  wire logic [63:0] spareInit,
    input  wire logic [63:0] spareCur,
    input  wire logic [47:0] eraseBudget,
    input  wire logic [7:0]  spareThreshold,
    input  wire logic [7:0]  eraseThreshold,
    input  wire logic [15:0] headerVersion,
    input  wire logic        sectorStart,
    input  wire logic        byteReq,
    input  wire logic [2:0]  recSel,
    input  wire logic [3:0]  byteSel,
    output logic      [7:0]  byteData,
    output logic             byteValid,
    output logic             layoutNew,
    output logic             thresholdExceeded
);

    function automatic logic [31:0] sat32(input logic [47:0] v);
        sat32 = (|v[47:32]) ? 32'hffff_ffff : v[31:0];
    endfunction : sat32

    function automatic logic [15:0] sat16(input logic [17:0] v);
        sat16 = (|v[17:16]) ? 16'hffff : v[15:0];
    endfunction : sat16

    // Event counters saturate instead of wrapping, so a report never falls back to zero.
    logic [1:0]  evInc [0:`SAR_NUM_CNT-1];
    logic [47:0] evCnt [0:`SAR_NUM_CNT-1];

    assign evInc[`SAR_CNT_TOTAL_ECC] = {1'b0, eccCorrected} + {1'b0, eccUncorrectable};
    assign evInc[`SAR_CNT_CORR_ECC]  = {1'b0, eccCorrected};
    assign evInc[`SAR_CNT_READS]     = {1'b0, flashReadDone};
    assign evInc[`SAR_CNT_UDMA_CRC]  = {1'b0, udmaCrcError && flashReadActive};
    assign evInc[`SAR_CNT_ERASE]     = {1'b0, blockErased};

    genvar g;
    generate
        for (g = 0; g < `SAR_NUM_CNT; g = g + 1) begin : gCnt
            logic [47:0] cnt_q;
            wire  [48:0] sum = {1'b0, cnt_q} + {47'h0, evInc[g]};
            wire  [47:0] cntNext = sum[48] ? 48'hffff_ffff_ffff : sum[47:0];
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    cnt_q <= 48'h0;
                end else begin
                    cnt_q <= cntNext;
                end
            end
            assign evCnt[g] = cnt_q;
        end
    endgenerate

    // Background scan over the chips, then the life estimate, then publish.
    pct_div_if div ();

    pct_divider uDivider (
        .core_clk (core_clk),
        .rstn     (rstn),
        .div      (div)
    );

    smart_rec_pkg::scanState_t state_q;
    smart_rec_pkg::scanState_t state_d;
    logic [1:0]  chipIdx_q;
    logic [7:0]  accPct_q;
    logic [15:0] accPctInit_q;
    logic [15:0] accPctCur_q;
    logic [15:0] accMinInit_q;
    logic [15:0] accMinCur_q;
    logic [17:0] accSumInit_q;
    logic [17:0] accSumCur_q;
    logic [7:0]  spareVal_q;
    logic [7:0]  spareWorst_q;
    logic [7:0]  lifeVal_q;
    logic [7:0]  lifeWorst_q;
    logic [15:0] pctInit_q;
    logic [15:0] pctCur_q;
    logic [15:0] minInit_q;
    logic [15:0] minCur_q;
    logic [15:0] sumInit_q;
    logic [15:0] sumCur_q;

    wire  [15:0] chipInit   = spareInit[{chipIdx_q, 4'h0} +: 16];
    wire  [15:0] chipCur    = spareCur[{chipIdx_q, 4'h0} +: 16];
    wire         firstChip  = (chipIdx_q == 2'h0);
    wire         lastChip   = (chipIdx_q == `SAR_LAST_CHIP);
    wire         chipDone   = (state_q == smart_rec_pkg::SC_CHIP_WAIT) && div.done;
    wire         lifeDone   = (state_q == smart_rec_pkg::SC_LIFE_WAIT) && div.done;
    wire         takePct    = chipDone && (firstChip || (div.quot < accPct_q));
    wire         takeMin    = chipDone && (firstChip || (chipCur < accMinCur_q));
    wire  [47:0] eraseUsed  = evCnt[`SAR_CNT_ERASE];
    wire  [47:0] lifeLeft   = (eraseBudget > eraseUsed) ? eraseBudget - eraseUsed : 48'h0;
    wire         inLife     = (state_q == smart_rec_pkg::SC_LIFE_GO);
    wire         commit     = (state_q == smart_rec_pkg::SC_COMMIT);

    assign div.start = (state_q == smart_rec_pkg::SC_CHIP_GO) || inLife;
    assign div.num   = inLife ? lifeLeft : {32'h0, chipCur};
    assign div.den   = inLife ? eraseBudget : {32'h0, chipInit};

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            smart_rec_pkg::SC_CHIP_GO:   state_d = smart_rec_pkg::SC_CHIP_WAIT;
            smart_rec_pkg::SC_CHIP_WAIT: begin
                if (div.done) begin
                    state_d = lastChip ? smart_rec_pkg::SC_LIFE_GO : smart_rec_pkg::SC_CHIP_GO;
                end
            end
            smart_rec_pkg::SC_LIFE_GO:   state_d = smart_rec_pkg::SC_LIFE_WAIT;
            smart_rec_pkg::SC_LIFE_WAIT: begin
                if (div.done) begin
                    state_d = smart_rec_pkg::SC_COMMIT;
                end
            end
            smart_rec_pkg::SC_COMMIT:    state_d = smart_rec_pkg::SC_CHIP_GO;
            default:                     state_d = smart_rec_pkg::SC_CHIP_GO;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= smart_rec_pkg::SC_CHIP_GO;
            chipIdx_q <= 2'h0;
        end else begin
            state_q   <= state_d;
            chipIdx_q <= chipDone ? chipIdx_q + 2'h1 : chipIdx_q;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            accPct_q     <= 8'h00;
            accPctInit_q <= 16'h0;
            accPctCur_q  <= 16'h0;
        end else if (takePct) begin
            accPct_q     <= div.quot;
            accPctInit_q <= chipInit;
            accPctCur_q  <= chipCur;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            accMinInit_q <= 16'h0;
            accMinCur_q  <= 16'h0;
        end else if (takeMin) begin
            accMinInit_q <= chipInit;
            accMinCur_q  <= chipCur;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            accSumInit_q <= 18'h0;
            accSumCur_q  <= 18'h0;
        end else if (chipDone) begin
            accSumInit_q <= (firstChip ? 18'h0 : accSumInit_q) + {2'h0, chipInit};
            accSumCur_q  <= (firstChip ? 18'h0 : accSumCur_q) + {2'h0, chipCur};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lifeVal_q   <= `SAR_PCT_FULL;
            lifeWorst_q <= `SAR_PCT_FULL;
        end else if (lifeDone) begin
            lifeVal_q   <= div.quot;
            lifeWorst_q <= (div.quot < lifeWorst_q) ? div.quot : lifeWorst_q;
        end
    end

    // Worst values only ever fall; they start at full health.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            spareVal_q   <= `SAR_PCT_FULL;
            spareWorst_q <= `SAR_PCT_FULL;
            pctInit_q    <= 16'h0;
            pctCur_q     <= 16'h0;
            minInit_q    <= 16'h0;
            minCur_q     <= 16'h0;
            sumInit_q    <= 16'h0;
            sumCur_q     <= 16'h0;
        end else if (commit) begin
            spareVal_q   <= accPct_q;
            spareWorst_q <= (accPct_q < spareWorst_q) ? accPct_q : spareWorst_q;
            pctInit_q    <= accPctInit_q;
            pctCur_q     <= accPctCur_q;
            minInit_q    <= accMinInit_q;
            minCur_q     <= accMinCur_q;
            sumInit_q    <= sat16(accSumInit_q);
            sumCur_q     <= sat16(accSumCur_q);
        end
    end

    // Record images, byte 0 in the low bits, so every field lands LSB first.
    logic [95:0] recOld [0:`SAR_NUM_RECORDS-1];
    logic [95:0] recNew [0:`SAR_NUM_RECORDS-1];

    assign recOld[`SAR_REC_SPARE] = {sumCur_q, sumInit_q, pctCur_q, pctInit_q, spareVal_q,
                                     `SAR_FLAGS_PREFAIL, `SAR_ID_SPARE};
    assign recOld[`SAR_REC_ERASE] = {16'h0, eraseUsed, lifeVal_q,
                                     `SAR_FLAGS_ADVISORY, `SAR_ID_ERASE};
    assign recOld[`SAR_REC_TOTAL_ECC] = {32'h0, sat32(evCnt[`SAR_CNT_TOTAL_ECC]),
                                         `SAR_FIXED_VALUE, `SAR_FLAGS_ADVISORY,
                                         `SAR_ID_TOTAL_ECC};
    assign recOld[`SAR_REC_CORR_ECC] = {32'h0, sat32(evCnt[`SAR_CNT_CORR_ECC]),
                                        `SAR_FIXED_VALUE, `SAR_FLAGS_ADVISORY,
                                        `SAR_ID_CORR_ECC};
    assign recOld[`SAR_REC_READS] = {32'h0, sat32(evCnt[`SAR_CNT_READS]),
                                     `SAR_FIXED_VALUE, `SAR_FLAGS_ADVISORY,
                                     `SAR_ID_READS};
    assign recOld[`SAR_REC_UDMA_CRC] = {32'h0, sat32(evCnt[`SAR_CNT_UDMA_CRC]),
                                        `SAR_FIXED_VALUE, `SAR_FLAGS_ADVISORY,
                                        `SAR_ID_UDMA_CRC};

    assign recNew[`SAR_REC_SPARE] = {`SAR_RESERVED_BYTE, sumCur_q, minCur_q, minInit_q,
                                     spareWorst_q, spareVal_q, `SAR_FLAGS_PREFAIL,
                                     `SAR_ID_SPARE};
    assign recNew[`SAR_REC_ERASE] = {`SAR_RESERVED_BYTE, eraseUsed, lifeWorst_q, lifeVal_q,
                                     `SAR_FLAGS_ADVISORY, `SAR_ID_ERASE};
    assign recNew[`SAR_REC_TOTAL_ECC] = {`SAR_RESERVED_BYTE, 16'h0,
                                         sat32(evCnt[`SAR_CNT_TOTAL_ECC]), `SAR_FIXED_VALUE,
                                         `SAR_FIXED_VALUE, `SAR_FLAGS_ADVISORY,
                                         `SAR_ID_TOTAL_ECC};
    assign recNew[`SAR_REC_CORR_ECC] = {`SAR_RESERVED_BYTE, 16'h0,
                                        sat32(evCnt[`SAR_CNT_CORR_ECC]), `SAR_FIXED_VALUE,
                                        `SAR_FIXED_VALUE, `SAR_FLAGS_ADVISORY,
                                        `SAR_ID_CORR_ECC};
    assign recNew[`SAR_REC_READS] = {`SAR_RESERVED_BYTE, evCnt[`SAR_CNT_READS],
                                     `SAR_FIXED_VALUE, `SAR_FIXED_VALUE,
                                     `SAR_FLAGS_ADVISORY, `SAR_ID_READS};
    assign recNew[`SAR_REC_UDMA_CRC] = {`SAR_RESERVED_BYTE, 16'h0,
                                        sat32(evCnt[`SAR_CNT_UDMA_CRC]), `SAR_FIXED_VALUE,
                                        `SAR_FIXED_VALUE, `SAR_FLAGS_ADVISORY,
                                        `SAR_ID_UDMA_CRC};

    // The layout is frozen at sector start so all six records agree with the header.
    smart_rec_pkg::layout_t layout_q;
    wire headerIsNew = (headerVersion == `SAR_VERSION_NEW);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            layout_q <= smart_rec_pkg::LAYOUT_OLD;
        end else if (sectorStart) begin
            layout_q <= headerIsNew ? smart_rec_pkg::LAYOUT_NEW : smart_rec_pkg::LAYOUT_OLD;
        end
    end

    wire         selInRange = (recSel < 3'(`SAR_NUM_RECORDS)) && (byteSel <= `SAR_LAST_BYTE);
    wire  [2:0]  recIdx     = selInRange ? recSel : 3'h0;
    wire  [95:0] recPicked  = (layout_q == smart_rec_pkg::LAYOUT_NEW) ? recNew[recIdx]
                                                                       : recOld[recIdx];
    wire  [7:0]  bytePicked = selInRange ? recPicked[{byteSel, 3'h0} +: 8] : 8'h00;

    // Only the spare and erase values take part in the health verdict.
    wire statusBad = (spareVal_q < spareThreshold) || (lifeVal_q < eraseThreshold);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            byteData          <= 8'h00;
            byteValid         <= 1'b0;
            layoutNew         <= 1'b0;
            thresholdExceeded <= 1'b0;
        end else begin
            byteData          <= byteReq ? bytePicked : byteData;
            byteValid         <= byteReq;
            layoutNew         <= (layout_q == smart_rec_pkg::LAYOUT_NEW);
            thresholdExceeded <= statusBad;
        end
    end

    corr_id_a: assert property (@(posedge core_clk) disable iff (!rstn)
        byteReq && recSel == `SAR_REC_CORR_ECC && byteSel == 4'h0
        |=> byteValid && byteData == `SAR_ID_CORR_ECC)
        else $error("correctable record id wrong");

    read_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
        flashReadDone && !(&evCnt[`SAR_CNT_READS])
        |=> evCnt[`SAR_CNT_READS] == $past(evCnt[`SAR_CNT_READS]) + 48'h1)
        else $error("read count did not advance");

    crc_fixed_a: assert property (@(posedge core_clk) disable iff (!rstn)
        byteReq && recSel == `SAR_REC_UDMA_CRC && byteSel == 4'h3
        |=> byteData == `SAR_FIXED_VALUE)
        else $error("crc record value not fixed");

    crc_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
        udmaCrcError && !flashReadActive |=> $stable(evCnt[`SAR_CNT_UDMA_CRC]))
        else $error("crc counted outside a flash read");

    status_source_a: assert property (@(posedge core_clk) disable iff (!rstn)
        spareVal_q >= spareThreshold && lifeVal_q >= eraseThreshold |=> !thresholdExceeded)
        else $error("status raised without spare or erase cause");

    spare_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
        spareVal_q < spareThreshold |=> thresholdExceeded)
        else $error("spare threshold not reported");

    reserved_byte_a: assert property (@(posedge core_clk) disable iff (!rstn)
        byteReq && layout_q == smart_rec_pkg::LAYOUT_NEW && byteSel == `SAR_LAST_BYTE
        |=> byteData == `SAR_RESERVED_BYTE)
        else $error("new layout byte eleven not zero");

    worst_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
        spareWorst_q <= spareVal_q && lifeWorst_q <= lifeVal_q)
        else $error("worst value above current value");

    layout_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !sectorStart |=> $stable(layout_q))
        else $error("layout changed inside a sector");

endmodule : smart_attribute_record_builder

// file: smart_rec_params.svh
// Constants for the health attribute record builder.
// Assumes inclusion by bare name from each design file that needs a figure.
`ifndef SMART_REC_PARAMS_SVH
`define SMART_REC_PARAMS_SVH

`define SAR_ID_SPARE      8'hc4
`define SAR_ID_ERASE      8'he5
`define SAR_ID_TOTAL_ECC  8'hcb
`define SAR_ID_CORR_ECC   8'hcc
`define SAR_ID_READS      8'he8
`define SAR_ID_UDMA_CRC   8'hc7

`define SAR_FLAGS_PREFAIL  16'h0003
`define SAR_FLAGS_ADVISORY 16'h0002
`define SAR_FIXED_VALUE    8'h64
`define SAR_RESERVED_BYTE  8'h00
`define SAR_PCT_FULL       8'h64
`define SAR_PCT_SCALE      56'h0000_0000_0000_64

`define SAR_VERSION_OLD   16'h0004
`define SAR_VERSION_NEW   16'h0010

`define SAR_NUM_CHIPS     4
`define SAR_LAST_CHIP     2'h3
`define SAR_NUM_RECORDS   6
`define SAR_LAST_BYTE     4'hb
`define SAR_NUM_CNT       5

`define SAR_REC_SPARE     3'h0
`define SAR_REC_ERASE     3'h1
`define SAR_REC_TOTAL_ECC 3'h2
`define SAR_REC_CORR_ECC  3'h3
`define SAR_REC_READS     3'h4
`define SAR_REC_UDMA_CRC  3'h5

`define SAR_CNT_TOTAL_ECC 0
`define SAR_CNT_CORR_ECC  1
`define SAR_CNT_READS     2
`define SAR_CNT_UDMA_CRC  3
`define SAR_CNT_ERASE     4

`define SAR_DIV_FIRST_STEP 3'h7
`define SAR_DIV_LATENCY    9

`endif

// file: smart_rec_pkg.sv
// Types used by the record builder for its scan sequence and its layout choice.
// Assumes nothing beyond a SystemVerilog compiler.
package smart_rec_pkg;

    typedef enum logic [2:0] {
        SC_CHIP_GO   = 3'b000,
        SC_CHIP_WAIT = 3'b001,
        SC_LIFE_GO   = 3'b010,
        SC_LIFE_WAIT = 3'b011,
        SC_COMMIT    = 3'b100
    } scanState_t;

    typedef enum logic {
        LAYOUT_OLD = 1'b0,
        LAYOUT_NEW = 1'b1
    } layout_t;

endpackage : smart_rec_pkg

// file: pct_div_if.sv
// Request and answer wires between the record builder and the percentage divider.
// Assumes both ends share core_clk.
`timescale 1ns/10ps
interface pct_div_if;
    logic        start;
    logic [47:0] num;
    logic [47:0] den;
    logic        done;
    logic [7:0]  quot;

    modport requester (output start, output num, output den, input done, input quot);
    modport divider   (input start, input num, input den, output done, output quot);
endinterface : pct_div_if

// file: pct_divider.sv
// Sequential divider that returns 100 * num / den, clamped to 100.
// Assumes a start is only given while the divider is idle.
`timescale 1ns/10ps
`include "smart_rec_params.svh"
module pct_divider (
    input wire logic   core_clk,
    input wire logic   rstn,
    pct_div_if.divider div
);
    logic [55:0] rem_q;
    logic [47:0] den_q;
    logic [2:0]  step_q;
    logic [7:0]  quot_q;
    logic        busy_q;
    logic        done_q;

    wire  [55:0] trialDen  = {8'h00, den_q} << step_q;
    wire         fits      = rem_q >= trialDen;
    wire  [55:0] scaledNum = {8'h00, div.num} * `SAR_PCT_SCALE;
    wire         accept    = div.start && !busy_q;

    // A zero or undersized denominator would overflow the quotient, so it is capped.
    assign div.quot = (quot_q > `SAR_PCT_FULL) ? `SAR_PCT_FULL : quot_q;
    assign div.done = done_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rem_q  <= 56'h0;
            den_q  <= 48'h0;
            step_q <= 3'h0;
            quot_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (accept) begin
            rem_q  <= scaledNum;
            den_q  <= div.den;
            step_q <= `SAR_DIV_FIRST_STEP;
            quot_q <= 8'h00;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (busy_q) begin
            rem_q          <= fits ? rem_q - trialDen : rem_q;
            quot_q[step_q] <= fits;
            step_q         <= step_q - 3'h1;
            busy_q         <= (step_q != 3'h0);
            done_q         <= (step_q == 3'h0);
        end else begin
            done_q <= 1'b0;
        end
    end

    // The edge that releases reset still finds the flops in reset, so it starts nothing.
    sequence divAccepted;
        rstn && div.start && !busy_q;
    endsequence

    sequence divFinished;
        ##`SAR_DIV_LATENCY done_q;
    endsequence

    property divLatency;
        @(posedge core_clk) disable iff (!rstn) divAccepted |-> divFinished;
    endproperty

    div_latency_a: assert property (divLatency)
        else $error("divider answer not nine cycles after start");

    pct_range_a: assert property (@(posedge core_clk) disable iff (!rstn)
        done_q |-> (div.quot <= `SAR_PCT_FULL))
        else $error("percentage above one hundred");

endmodule : pct_divider

// file: smart_host_model.sv
// Host-side model that reads single record bytes out of the builder.
// Assumes the builder registers its answer on the same edge that takes a request.
`timescale 1ns/10ps
module smart_host_model (
    input  wire logic       core_clk,
    output logic            byteReq,
    output logic      [2:0] recSel,
    output logic      [3:0] byteSel,
    input  wire logic [7:0] byteData,
    input  wire logic       byteValid
);
    initial begin
        byteReq = 1'b0;
        recSel  = 3'h0;
        byteSel = 4'h0;
    end

    // Returns the answer flag above the answered byte.
    task automatic rd(input logic [2:0] r, input logic [3:0] b, output logic [8:0] v);
        @(posedge core_clk);
        byteReq <= 1'b1;
        recSel  <= r;
        byteSel <= b;
        @(posedge core_clk);
        byteReq <= 1'b0;
        #1 v = {byteValid, byteData};
    endtask : rd
endmodule : smart_host_model

// file: test_smart_attribute_record_builder.sv
// Self-checking bench for the attribute record builder.
// Assumes the host model and the builder share core_clk.
`timescale 1ns/10ps
module test_smart_attribute_record_builder;
    logic        core_clk = 1'b0, rstn = 1'b0, sectorStart = 1'b0, thr, lay;
    logic [5:0]  evt = 6'h00;
    logic [63:0] spareInit = {4{16'h0064}}, spareCur = {4{16'h0064}};
    logic [47:0] eraseBudget = 48'h0000_0000_0004;
    logic [7:0]  spareThreshold = 8'h00, eraseThreshold = 8'h00, byteData;
    logic [15:0] headerVersion = 16'h0004;
    logic [2:0]  recSel;
    logic [3:0]  byteSel;
    logic        byteReq, byteValid;
    int          err_total = 0, comparisons = 0;

    initial forever #10 core_clk = ~core_clk;

    smart_attribute_record_builder dut (.core_clk(core_clk), .rstn(rstn),
        .flashReadActive(evt[5]), .flashReadDone(evt[4]), .eccUncorrectable(evt[3]),
        .eccCorrected(evt[2]), .udmaCrcError(evt[1]), .blockErased(evt[0]),
        .spareInit(spareInit), .spareCur(spareCur), .eraseBudget(eraseBudget),
        .spareThreshold(spareThreshold), .eraseThreshold(eraseThreshold),
        .headerVersion(headerVersion), .sectorStart(sectorStart), .byteReq(byteReq),
        .recSel(recSel), .byteSel(byteSel), .byteData(byteData), .byteValid(byteValid),
        .layoutNew(lay), .thresholdExceeded(thr));
    smart_host_model host (.core_clk(core_clk), .byteReq(byteReq), .recSel(recSel),
        .byteSel(byteSel), .byteData(byteData), .byteValid(byteValid));

    task automatic chk(input logic [8:0] s, input logic [8:0] e, input string m);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, m, s, e);
        end
    endtask : chk

    task automatic cb(input logic [2:0] r, input logic [3:0] b, input logic [7:0] e);
        logic [8:0] v;
        host.rd(r, b, v);
        chk(v, {1'b1, e}, $sformatf("record %0d byte %0d", r, b));
    endtask : cb

    task automatic ev(input logic [5:0] e);
        @(posedge core_clk) evt <= e;
        @(posedge core_clk) evt <= 6'h00;
    endtask : ev

    task automatic t_ids();
        logic [7:0] ids [6] = '{8'hc4, 8'he5, 8'hcb, 8'hcc, 8'he8, 8'hc7};
        for (int r = 0; r < 6; r++) begin
            cb(3'(r), 4'h0, ids[r]);
            cb(3'(r), 4'h1, (r == 0) ? 8'h03 : 8'h02);
            cb(3'(r), 4'h2, 8'h00);
            if (r > 1) cb(3'(r), 4'h3, 8'h64);
        end
        cb(3'h6, 4'h0, 8'h00);
        cb(3'h0, 4'hc, 8'h00);
        $display("test ids done");
    endtask : t_ids

    task automatic t_counts();
        logic [7:0] n [4] = '{8'h04, 8'h03, 8'h02, 8'h01};
        ev(6'b001100); ev(6'b000100); ev(6'b000100); ev(6'b010000); ev(6'b010000);
        ev(6'b100010); ev(6'b000010); ev(6'b000001);
        for (int r = 2; r < 6; r++) begin
            cb(3'(r), 4'h4, n[r-2]);
            cb(3'(r), 4'h5, 8'h00);
        end
        cb(3'h1, 4'h4, 8'h01);
        repeat (120) @(posedge core_clk);
        cb(3'h1, 4'h3, 8'h4b);
        chk({8'h00, thr}, 9'h000, "status from counters");
        @(posedge core_clk) eraseThreshold <= 8'h50;
        repeat (3) @(posedge core_clk);
        chk({8'h00, thr}, 9'h001, "erase threshold");
        @(posedge core_clk) eraseThreshold <= 8'h4b;
        repeat (3) @(posedge core_clk);
        chk({8'h00, thr}, 9'h000, "erase threshold equal");
        $display("test counts done");
    endtask : t_counts

    task automatic t_spare();
        logic [7:0] e [12] = '{8'hc4, 8'h03, 8'h00, 8'h1e, 8'h64, 8'h00,
                               8'h1e, 8'h00, 8'h90, 8'h01, 8'h04, 8'h01};
        @(posedge core_clk) spareCur <= {16'h0064, 16'h001e, 16'h0050, 16'h0032};
        repeat (120) @(posedge core_clk);
        for (int b = 3; b < 12; b++) cb(3'h0, 4'(b), e[b]);
        @(posedge core_clk) spareThreshold <= 8'h1f;
        repeat (3) @(posedge core_clk);
        chk({8'h00, thr}, 9'h001, "spare threshold");
        @(posedge core_clk) spareThreshold <= 8'h1e;
        repeat (3) @(posedge core_clk);
        chk({8'h00, thr}, 9'h000, "spare threshold equal");
        $display("test spare done");
    endtask : t_spare

    task automatic t_new();
        logic [7:0] n [4] = '{8'h04, 8'h03, 8'h02, 8'h01};
        logic [7:0] s [12] = '{8'hc4, 8'h03, 8'h00, 8'h1e, 8'h1e, 8'h64,
                               8'h00, 8'h1e, 8'h00, 8'h04, 8'h01, 8'h00};
        @(posedge core_clk) begin
            headerVersion <= 16'h0010;
            sectorStart   <= 1'b1;
        end
        @(posedge core_clk) sectorStart <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk({8'h00, lay}, 9'h001, "layout flag");
        for (int b = 3; b < 12; b++) cb(3'h0, 4'(b), s[b]);
        for (int r = 2; r < 6; r++) begin
            cb(3'(r), 4'h4, 8'h64);
            cb(3'(r), 4'h5, n[r-2]);
            cb(3'(r), 4'h4 + 4'(r), 8'h00);
            cb(3'(r), 4'hb, 8'h00);
        end
        cb(3'h1, 4'h4, 8'h4b);
        cb(3'h1, 4'h5, 8'h01);
        cb(3'h1, 4'hb, 8'h00);
        $display("test new layout done");
    endtask : t_new

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        t_ids();
        t_counts();
        t_spare();
        t_new();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        test_done();
    end
endmodule : test_smart_attribute_record_builder
